/* File: logic/ocr_pkg.sv */
// Purpose: Shared constants for the card power-up and operating-conditions block
// Assumes: 40 MHz system clock; bus clock sampled, never used as a clock
// Notes:   Frame layout follows the 48-bit command/response format
package op_cond_pkg;
   // System clock and power-up deadline
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned INIT_TIME_MS = 1000;
   localparam int unsigned INIT_MAX_CYCLES = (CLK_HZ / 1000) * INIT_TIME_MS;

   // Operating-conditions register layout
   localparam int unsigned REG_W = 32;
   localparam int unsigned BUSY_BIT = 31;
   localparam int unsigned LOWV_BIT = 7;
   localparam int unsigned HIGHV_LSB = 15;
   localparam int unsigned HIGHV_MSB = 23;
   localparam logic [31:0] HIGHV_FIELD = 32'h00FF_8000;
   localparam logic [31:0] LOWV_FIELD = 32'h0000_0080;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // Command frame layout, bits after the start bit
   localparam int unsigned FRAME_BITS = 48;
   localparam int unsigned TAIL_BITS = 47;
   localparam int unsigned DIR_POS = 46;
   localparam int unsigned IDX_MSB = 45;
   localparam int unsigned IDX_LSB = 40;
   localparam int unsigned ARG_MSB = 39;
   localparam int unsigned ARG_LSB = 8;
   localparam logic [5:0] OP_COND_CMD = 6'h01;
   localparam logic [5:0] RESP_CHECK_FIELD = 6'h3F;
   localparam logic [6:0] RESP_CRC_FIELD = 7'h7F;

   // Bus clocks between command end and response start
   localparam int unsigned RESP_GAP_CLOCKS = 2;
endpackage

/* File: logic/frame_if.sv */
// Purpose: Carrier between the link sampler and the command frame receiver
// Assumes: All signals on clk; sample_en is a one-cycle pulse
// Notes:   hold keeps the receiver from parsing the card's own response
`timescale 1ns/10ps
interface frame_if;
   logic sample_en;
   logic bit_in;
   logic hold;
   logic frame_valid;
   logic [5:0] index;
   logic [31:0] arg;

   modport rx (
      input sample_en,
      input bit_in,
      input hold,
      output frame_valid,
      output index,
      output arg
   );
   modport ctl (
      output sample_en,
      output bit_in,
      output hold,
      input frame_valid,
      input index,
      input arg
   );
endinterface

/* File: logic/cmd_frame_rx.sv */
// Purpose: Collect 48-bit host command frames from sampled command-line bits
// Assumes: sample_en marks a rising bus clock edge, bit_in already synchronised
// Notes:   The checksum field is carried but not verified
`timescale 1ns/10ps
module cmd_frame_rx (
   input wire logic clk,
   input wire logic nrst,
   frame_if.rx fr
);
   logic [5:0] cnt_r, cnt_nxt;
   logic [45:0] sr_r, sr_nxt;
   logic valid_r, valid_nxt;
   logic [5:0] idx_r, idx_nxt;
   logic [31:0] arg_r, arg_nxt;
   logic [46:0] full;

   assign full = {sr_r, fr.bit_in};

   // Hunt for a start bit, then shift the tail in on each sampled edge
   always_comb begin
      cnt_nxt = cnt_r;
      sr_nxt = sr_r;
      valid_nxt = 1'b0;
      idx_nxt = idx_r;
      arg_nxt = arg_r;
      if (fr.hold) begin
         cnt_nxt = 6'd0;
      end else if (fr.sample_en) begin
         if (cnt_r == 6'd0) begin
            if (!fr.bit_in) begin
               cnt_nxt = 6'd1;
            end
         end else if (cnt_r == 6'(op_cond_pkg::TAIL_BITS)) begin
            cnt_nxt = 6'd0;
            // Host direction bit high and end bit high mark a real command
            valid_nxt = full[op_cond_pkg::DIR_POS] & fr.bit_in;
            idx_nxt = full[op_cond_pkg::IDX_MSB:op_cond_pkg::IDX_LSB];
            arg_nxt = full[op_cond_pkg::ARG_MSB:op_cond_pkg::ARG_LSB];
         end else begin
            cnt_nxt = cnt_r + 6'd1;
            sr_nxt = full[45:0];
         end
      end
   end

   // State registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 6'd0;
         sr_r <= '0;
         valid_r <= 1'b0;
         idx_r <= 6'h00;
         arg_r <= 32'h0000_0000;
      end else begin
         cnt_r <= cnt_nxt;
         sr_r <= sr_nxt;
         valid_r <= valid_nxt;
         idx_r <= idx_nxt;
         arg_r <= arg_nxt;
      end
   end

   assign fr.frame_valid = valid_r;
   assign fr.index = idx_r;
   assign fr.arg = arg_r;
endmodule

/* File: logic/card_op_conditions_busy_reg.sv */
// Purpose: Operating-conditions register of a flash card with power-up busy bit
// Assumes: Bus clock and command line arrive asynchronously to clk (40 MHz)
// Notes:   Answers only the operating-condition negotiation command, open-drain
`timescale 1ns/10ps

// Functional notes
// - Command line bits are taken only on rising bus clock edges.
// - Register is reachable only through its dedicated bus command.
// - Card holds a 32-bit operating-conditions register with one status bit.
// - Bits 23:15 ones, bit 7 set on dual-voltage cards, others zero.
// - Bit 31 reads low during power-up, high once it has finished.
// - Busy bit is wired-AND across cards; low means some card busy.
// - Power-up finishes within 1 second of first valid-range command.
// - After power-up the card ignores everything until the negotiation command.
module card_op_conditions_busy_reg #(
   parameter bit DUAL_VOLTAGE = 1'b0,
   parameter int unsigned INIT_CYCLES = op_cond_pkg::INIT_MAX_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic bus_clk,
   input wire logic cmd_i,
   output logic cmd_o,
   output logic cmd_oe,
   output logic [31:0] supply_window_and_powerup,
   output logic powerup_done,
   output logic init_running
);
   typedef enum logic [1:0] {ST_LISTEN, ST_GAP, ST_SEND} resp_state_t;

   frame_if fr ();

   logic clk_s1_r, clk_s2_r, clk_s3_r;
   logic clk_s1_nxt, clk_s2_nxt, clk_s3_nxt;
   logic cmd_s1_r, cmd_s2_r;
   logic cmd_s1_nxt, cmd_s2_nxt;
   logic bus_rise, bus_fall;

   // Two flops on each pin, a third clock flop only for edge finding
   always_comb begin
      clk_s1_nxt = bus_clk;
      clk_s2_nxt = clk_s1_r;
      clk_s3_nxt = clk_s2_r;
      cmd_s1_nxt = cmd_i;
      cmd_s2_nxt = cmd_s1_r;
   end

   // Reset levels match the idle pins, so no false edge follows reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clk_s1_r <= 1'b0;
         clk_s2_r <= 1'b0;
         clk_s3_r <= 1'b0;
         cmd_s1_r <= 1'b1;
         cmd_s2_r <= 1'b1;
      end else begin
         clk_s1_r <= clk_s1_nxt;
         clk_s2_r <= clk_s2_nxt;
         clk_s3_r <= clk_s3_nxt;
         cmd_s1_r <= cmd_s1_nxt;
         cmd_s2_r <= cmd_s2_nxt;
      end
   end

   assign bus_rise = clk_s2_r & ~clk_s3_r;
   assign bus_fall = ~clk_s2_r & clk_s3_r;   // Outputs change here, half a clock early

   // Bus clock phases must span more than one clk period or an edge is missed
   assign fr.sample_en = bus_rise;
   assign fr.bit_in = cmd_s2_r;

   cmd_frame_rx u_rx (
      .clk(clk),
      .nrst(nrst),
      .fr(fr)
   );

   localparam logic [31:0] WINDOW =
      op_cond_pkg::HIGHV_FIELD | (DUAL_VOLTAGE ? op_cond_pkg::LOWV_FIELD : 32'h0000_0000);

   logic neg_cmd;
   logic range_ok;
   logic started_r, started_nxt;
   logic done_r, done_nxt;
   logic [31:0] init_cnt_r, init_cnt_nxt;

   // only the negotiation command is acted on
   assign neg_cmd = fr.frame_valid && (fr.index == op_cond_pkg::OP_COND_CMD);
   assign range_ok = |(fr.arg & WINDOW);

   // Power-up routine timer, armed by the first command with a usable range
   always_comb begin
      started_nxt = started_r;
      done_nxt = done_r;
      init_cnt_nxt = init_cnt_r;
      if (neg_cmd && range_ok) begin
         started_nxt = 1'b1;
      end
      if (started_r && !done_r) begin
         if (init_cnt_r >= INIT_CYCLES - 32'd1) begin
            done_nxt = 1'b1;   // Busy flag only ever sets; only reset clears it
         end else begin
            init_cnt_nxt = init_cnt_r + 32'd1;
         end
      end
   end

   // Power-up state registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         started_r <= 1'b0;
         done_r <= 1'b0;
         init_cnt_r <= 32'h0000_0000;
      end else begin
         started_r <= started_nxt;
         done_r <= done_nxt;
         init_cnt_r <= init_cnt_nxt;
      end
   end

   logic [31:0] supply_window_and_powerup_r, supply_window_and_powerup_nxt;

   // register value, only the busy bit varies
   // Busy bit follows done_nxt so the word and powerup_done never disagree
   always_comb begin
      supply_window_and_powerup_nxt = WINDOW;
      supply_window_and_powerup_nxt[op_cond_pkg::BUSY_BIT] = done_nxt;
   end

   // Register word, cleared while in reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         supply_window_and_powerup_r <= op_cond_pkg::REG_RESET;
      end else begin
         supply_window_and_powerup_r <= supply_window_and_powerup_nxt;
      end
   end

   resp_state_t st_r, st_nxt;
   logic [47:0] sh_r, sh_nxt;
   logic [5:0] bit_cnt_r, bit_cnt_nxt;
   logic drive_low_r, drive_low_nxt;

   // the register leaves the card only in this command's response
   always_comb begin
      st_nxt = st_r;
      sh_nxt = sh_r;
      bit_cnt_nxt = bit_cnt_r;
      drive_low_nxt = drive_low_r;
      case (st_r)
         ST_LISTEN: begin
            drive_low_nxt = 1'b0;
            if (neg_cmd) begin
               st_nxt = ST_GAP;
               bit_cnt_nxt = 6'd0;
               // Start 0, direction 0, check field, register, crc field, end 1
               sh_nxt = {2'b00, op_cond_pkg::RESP_CHECK_FIELD, supply_window_and_powerup_r,
                         op_cond_pkg::RESP_CRC_FIELD, 1'b1};
            end
         end
         ST_GAP: begin
            if (bus_fall) begin
               if (bit_cnt_r == 6'(op_cond_pkg::RESP_GAP_CLOCKS - 1)) begin
                  st_nxt = ST_SEND;
                  bit_cnt_nxt = 6'd0;
                  drive_low_nxt = ~sh_r[47];
               end else begin
                  bit_cnt_nxt = bit_cnt_r + 6'd1;
               end
            end
         end
         ST_SEND: begin
            if (bus_fall) begin
               if (bit_cnt_r == 6'(op_cond_pkg::FRAME_BITS - 1)) begin
                  st_nxt = ST_LISTEN;
                  drive_low_nxt = 1'b0;
               end else begin
                  bit_cnt_nxt = bit_cnt_r + 6'd1;
                  sh_nxt = {sh_r[46:0], 1'b1};
                  // open-drain, a one is left to the pull-up
                  drive_low_nxt = ~sh_r[46];
               end
            end
         end
         default: begin
            st_nxt = ST_LISTEN;
            drive_low_nxt = 1'b0;
         end
      endcase
   end

   // Response state registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= ST_LISTEN;
         sh_r <= '1;
         bit_cnt_r <= 6'd0;
         drive_low_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         sh_r <= sh_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         drive_low_r <= drive_low_nxt;
      end
   end

   // Receiver is held while the card owns the line
   assign fr.hold = (st_r != ST_LISTEN);

   // Open-drain pin: only ever pulled low, so a busy card wins the wired-AND
   assign cmd_o = 1'b0;
   assign cmd_oe = drive_low_r;
   assign supply_window_and_powerup = supply_window_and_powerup_r;
   assign powerup_done = done_r;
   assign init_running = started_r & ~done_r;
endmodule

/* File: sim/ocr_checks_properties.sv */
// Purpose: Port-level checks on the card power-up register block
// Assumes: One clk domain, nrst asynchronous active low
// Notes: Timer bounds follow the block's INIT_CYCLES parameter
`timescale 1ns/10ps
module cond_checks #(
   parameter bit DUAL_VOLTAGE = 1'b0,
   parameter int unsigned INIT_CYCLES = 50
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic bus_clk,
   input wire logic cmd_o,
   input wire logic cmd_oe,
   input wire logic [31:0] supply_window_and_powerup,
   input wire logic powerup_done,
   input wire logic init_running
);
   localparam logic [31:0] WIN = DUAL_VOLTAGE ? 32'h00ff_8080 : 32'h00ff_8000;
   int unsigned run_r, run_nxt;
   logic [7:0] low_r, low_nxt;
   // Timer and idle-line counters; idle one saturates so it never wraps
   always_comb begin
      run_nxt = (init_running && !powerup_done) ? run_r + 1 : run_r;
      low_nxt = cmd_oe ? 8'h00 : ((low_r == 8'hff) ? low_r : low_r + 8'h01);
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run_r <= 0;
         low_r <= 8'h00;
      end else begin
         run_r <= run_nxt;
         low_r <= low_nxt;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Start and direction bits pull the line, index bits leave it high
   sequence start_pair_s;
      cmd_oe [*8];
   endsequence
   sequence index_ones_s;
      !cmd_oe [*8];
   endsequence
   window_fixed_a: assert property ($past(nrst) |->
      supply_window_and_powerup[30:0] == WIN[30:0])
      else $error("voltage window bits wrong");
   busy_mirror_a: assert property (supply_window_and_powerup[31] == powerup_done)
      else $error("busy bit differs from done flag");
   busy_sticky_a: assert property (powerup_done |=> powerup_done)
      else $error("busy bit cleared without reset");
   init_bound_a: assert property (run_r <= INIT_CYCLES + 2)
      else $error("power-up took too long");
   init_early_a: assert property ($rose(powerup_done) |->
      (run_r + 2 >= INIT_CYCLES) && $past(init_running))
      else $error("power-up ended early or without timer");
   pull_only_a: assert property (cmd_o == 1'b0)
      else $error("command line driven high");
   edge_launch_a: assert property ($changed(cmd_oe) |-> !$past(bus_clk, 2))
      else $error("reply bit changed outside clock low phase");
   resp_start_a: assert property ($rose(cmd_oe) && low_r > 8'h78 |->
      start_pair_s ##[1:12] index_ones_s)
      else $error("reply framing wrong");
endmodule
bind card_op_conditions_busy_reg cond_checks #(.DUAL_VOLTAGE(DUAL_VOLTAGE),
   .INIT_CYCLES(INIT_CYCLES)) u_chk (.clk(clk), .nrst(nrst), .bus_clk(bus_clk),
   .cmd_o(cmd_o), .cmd_oe(cmd_oe),
   .supply_window_and_powerup(supply_window_and_powerup),
   .powerup_done(powerup_done), .init_running(init_running));

/* File: sim/host_model.sv */
// Purpose: Bus host that clocks frames in and collects card replies
// Assumes: Line has a pull-up; host_oe high pulls it low
// Notes: Clock stands low between frames
`timescale 1ns/10ps
module host_model (
   input wire logic cmd_line,
   output logic bus_clk,
   output logic host_oe
);
   logic smp;
   initial begin
      bus_clk = 1'b0;
      host_oe = 1'b0;
   end
   task automatic tick(input logic pull);
      host_oe = pull;
      #100 bus_clk = 1'b1;
      smp = cmd_line;
      #100 bus_clk = 1'b0;
   endtask
   task automatic wake();
      // Step off the clk edge so bus clock never moves as clk samples it
      #7;
      repeat (74) tick(1'b0);
   endtask
   // Frame out MSB first, then clock on until a start bit or a bound
   task automatic xfer(input logic [47:0] f, output logic hit, output logic [47:0] rx);
      hit = 1'b0;
      rx = '1;
      #7;
      foreach (f[i]) tick(!f[i]);
      for (int n = 0; n < 60 && !hit; n++) begin
         tick(1'b0);
         hit = !smp;
      end
      rx[47] = !hit;
      for (int k = 46; k >= 0 && hit; k--) begin
         tick(1'b0);
         rx[k] = smp;
      end
      repeat (3) tick(1'b0);
   endtask
endmodule

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the card power-up register block
// Assumes: Dual-voltage card, shortened power-up timer
// Notes: Args come from an xorshift source with a fixed seed
`timescale 1ns/10ps
module testbench;
   localparam int unsigned INIT_N = 2000;
   localparam logic [31:0] WIN = 32'h00ff_8080;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cmd_o, cmd_oe, powerup_done, init_running, bus_clk, host_oe, hit, cmd_i;
   logic [31:0] supply_window_and_powerup;
   logic [47:0] rx, f;
   logic [31:0] seed = 32'h0000_55e4;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   // Pull-up AND both pull-downs gives the line level
   assign cmd_i = !host_oe && !cmd_oe;
   card_op_conditions_busy_reg #(.DUAL_VOLTAGE(1'b1), .INIT_CYCLES(INIT_N)) u_dut (
      .clk(clk), .nrst(nrst), .bus_clk(bus_clk), .cmd_i(cmd_i), .cmd_o(cmd_o),
      .cmd_oe(cmd_oe), .supply_window_and_powerup(supply_window_and_powerup),
      .powerup_done(powerup_done),
      .init_running(init_running));
   host_model u_host (.cmd_line(cmd_i), .bus_clk(bus_clk), .host_oe(host_oe));
   always #12.5 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [47:0] frame(input logic [5:0] ix, input logic [31:0] a);
      return {2'b01, ix, a, 8'hff};
   endfunction
   // Reply carries the snapshot of the register between fixed fields
   function automatic logic [47:0] reply(input logic busy);
      return {8'h3f, busy, WIN[30:0], 8'hff};
   endfunction
   task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      check("register reset", {16'h0000, WIN}, supply_window_and_powerup);
      u_host.wake();
      // Other indices and broken frames get no answer before negotiation
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         f = frame((seed[5:0] == 6'h01) ? 6'h3f : seed[5:0], xs(seed));
         if (i == 4) f = frame(6'h01, WIN) & ~48'h0000_0000_0001;
         if (i == 5) f = frame(6'h01, WIN) & ~48'h4000_0000_0000;
         u_host.xfer(f, hit, rx);
         check("no reply", 1'b0, hit);
         check("timer idle", 1'b0, init_running);
      end
      $display("ignore test done");
      // Queries outside the window answer but leave the timer off
      for (int i = 0; i < 2; i++) begin
         seed = xs(seed);
         u_host.xfer(frame(6'h01, i ? (seed & 32'h7f00_7f7f) : 32'h0000_0000), hit, rx);
         check("query reply", reply(1'b0), rx);
         check("no start", 1'b0, init_running);
      end
      $display("query test done");
      // Low-voltage bit alone is a valid range on this card
      u_host.xfer(frame(6'h01, 32'h0000_0080), hit, rx);
      check("first busy", reply(1'b0), rx);
      check("timer on", 1'b1, init_running);
      for (int n = 0; n < 10 && rx[39] !== 1'b1; n++) begin
         seed = xs(seed);
         u_host.xfer(frame(6'h01, seed), hit, rx);
      end
      check("ready reply", reply(1'b1), rx);
      check("done flag", 1'b1, powerup_done);
      $display("power-up test done");
      // A second reset brings the card back to busy
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      check("done cleared", 1'b0, powerup_done);
      u_host.xfer(frame(6'h01, 32'h0000_8000), hit, rx);
      check("busy again", reply(1'b0), rx);
      $display("reset test done");
      stop_test();
   end
endmodule
